/* src/gsp_pkg.sv */
// Constants shared by the global sector protect decoder
package gsp_pkg;

  // Register byte offsets on the register bus
  localparam logic [7:0] REG_EVENT = 8'h00;
  localparam logic [7:0] REG_CLEAR = 8'h04;
  localparam logic [7:0] REG_ENABLE = 8'h08;
  localparam logic [7:0] REG_PROT = 8'h0c;
  localparam logic [7:0] REG_SUSP = 8'h10;
  localparam logic [7:0] REG_STATBYTE = 8'h14;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serial opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_RDSR = 8'h05;

  // First status byte fields
  localparam int LOCK_POS = 7;
  localparam int WP_POS = 4;
  localparam int SWP_LO = 2;
  localparam int WEL_POS = 1;
  localparam int GLB_HI = 5;
  localparam int GLB_LO = 2;
  localparam logic [3:0] GLB_PROTECT = 4'hf;
  localparam logic [3:0] GLB_UNPROTECT = 4'h0;
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL = 2'h3;

  // Event bit positions
  localparam int EV_PROTECT = 0;
  localparam int EV_UNPROTECT = 1;
  localparam int EV_ABORT = 2;
  localparam int EV_REFUSED = 3;
  localparam int EV_W = 4;

  // Reset values and bits per byte
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_WEL = 1'b0;
  localparam logic RST_SECTOR = 1'b1;
  localparam logic [EV_W-1:0] RST_EVENT = 4'h0;
  localparam logic [EV_W-1:0] RST_ENABLE = 4'h0;
  localparam int BITS_PER_BYTE = 8;

endpackage : gsp_pkg

/* src/gsp_sync.sv */
// Two flip-flop synchroniser for pin inputs
module gsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule : gsp_sync

/* src/gsp_decoder.sv */
// Global sector protect decoder with serial link and register bus
// Functional notes
// RULE1 - Bits 5:2 all ones protect every sector
// RULE2 - Bits 5:2 all zeros unprotect every sector
// RULE3 - Mixed bits 5:2 leave protection unchanged
// RULE4 - Pin low and lock set ignores write
// RULE5 - Pin high and locked: only lock loads
// RULE6 - Host rewrites after clearing lock for global
// RULE7 - Only lock bit is stored from byte
// RULE8 - Readback bits 5:2 show pin, sector status; code puts pin in bit 4 and sector status in bits 3:2, bit 5 reads 0
// RULE9 - Protect during suspend aborts, clears write latch
// RULE10 - Host keeps suspended sectors unprotected
// RULE11 - 00h unprotects, 7Fh protects, FFh protects+locks
// RULE12 - 0Fh clears lock, F0h sets lock only
// RULE13 - Global functions only via status write one
// RULE14 - Unlocked write with bit 7 sets lock
// RULE15 - Status write needs write latch set
// RULE16 - Power-up sets all sector bits
// RULE17 - One bit per sector, 32 sectors
// RULE18 - Clear latch at end; apply on boundary
//
// Our own choices: the register addresses and register access over AXI4-Lite.
module gsp_decoder #(
  parameter int NUM_SECTORS = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic wp_n,
  // Register bus write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  typedef enum logic [2:0] {
    GSP_IDLE, GSP_OPCODE, GSP_SIMPLE, GSP_WRSR, GSP_RDSR, GSP_IGNORE
  } gsp_mode_t;

  // Synchronised pins
  logic sck_s, cs_n_s, si_s, wp_n_s;
  logic sck_d, cs_n_d;

  gsp_sync #(.W(4), .RST_VAL(4'h6)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({spi_sck, spi_cs_n, spi_si, wp_n}),
    .q({sck_s, cs_n_s, si_s, wp_n_s})
  );

  // Serial side state
  gsp_mode_t mode, next_mode;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] sh_in, next_sh_in;
  logic [7:0] opcode, next_opcode;
  logic [7:0] wr_data, next_wr_data;
  logic have_data, next_have_data;
  logic [7:0] out_sh, next_out_sh;
  logic so_q, next_so_q;
  logic write_latch_bit, next_wel;
  logic lock, next_lock;
  logic [NUM_SECTORS-1:0] prot, next_prot;
  logic [gsp_pkg::EV_W-1:0] ev, next_ev;
  logic [NUM_SECTORS-1:0] susp;

  logic sck_rise, sck_fall, cs_start, cs_end;
  logic [7:0] byte_in;
  logic [1:0] swp;
  logic [7:0] stat_byte;
  logic [3:0] glb;

  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign cs_start = ~cs_n_s & cs_n_d;
  assign cs_end = cs_n_s & ~cs_n_d;
  assign byte_in = {sh_in[6:0], si_s};
  assign glb = wr_data[gsp_pkg::GLB_HI:gsp_pkg::GLB_LO];

  // Readback of the first status byte
  always_comb begin
    if (&prot) begin
      swp = gsp_pkg::SWP_ALL;
    end else if (|prot) begin
      swp = gsp_pkg::SWP_SOME;
    end else begin
      swp = gsp_pkg::SWP_NONE;
    end
    stat_byte = 8'h00;
    stat_byte[gsp_pkg::LOCK_POS] = lock;
    stat_byte[gsp_pkg::WP_POS] = wp_n_s; // [RULE8]
    stat_byte[gsp_pkg::SWP_LO +: 2] = swp; // [RULE8]
    stat_byte[gsp_pkg::WEL_POS] = write_latch_bit;
  end

  always_comb begin
    next_mode = mode;
    next_bit_cnt = bit_cnt;
    next_sh_in = sh_in;
    next_opcode = opcode;
    next_wr_data = wr_data;
    next_have_data = have_data;
    next_out_sh = out_sh;
    next_so_q = so_q;
    next_wel = write_latch_bit;
    next_lock = lock;
    next_prot = prot;
    next_ev = '0;
    if (cs_start) begin
      next_mode = GSP_OPCODE;
      next_bit_cnt = 3'h0;
      next_have_data = 1'b0;
    end else if (cs_end) begin
      next_mode = GSP_IDLE;
      unique case (mode)
        GSP_SIMPLE: begin
          if (bit_cnt == 3'h0) begin
            next_wel = (opcode == gsp_pkg::OP_WREN);
          end
        end
        GSP_WRSR: begin
          next_wel = 1'b0; // [RULE18]
          if (!write_latch_bit) begin
            next_ev[gsp_pkg::EV_REFUSED] = 1'b1; // [RULE15]
          end else if (bit_cnt != 3'h0 || !have_data) begin
            next_ev[gsp_pkg::EV_REFUSED] = 1'b1; // [RULE18]
          end else if (!wp_n_s && lock) begin
            next_ev[gsp_pkg::EV_REFUSED] = 1'b1; // [RULE4]
          end else if (lock) begin
            next_lock = wr_data[gsp_pkg::LOCK_POS]; // [RULE5] [RULE6] [RULE12]
          end else begin
            next_lock = wr_data[gsp_pkg::LOCK_POS]; // [RULE7] [RULE11] [RULE14]
            if (glb == gsp_pkg::GLB_PROTECT) begin
              if (|susp) begin
                next_ev[gsp_pkg::EV_ABORT] = 1'b1; // [RULE9] [RULE10]
              end else begin
                next_prot = '1; // [RULE1] [RULE17]
                next_ev[gsp_pkg::EV_PROTECT] = 1'b1;
              end
            end else if (glb == gsp_pkg::GLB_UNPROTECT) begin
              next_prot = '0; // [RULE2] [RULE17]
              next_ev[gsp_pkg::EV_UNPROTECT] = 1'b1;
            end
            // Mixed patterns leave every sector bit alone [RULE3]
          end
        end
        default: begin
        end
      endcase
    end else if (!cs_n_s && sck_rise && mode != GSP_IDLE) begin
      next_sh_in = byte_in;
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (mode == GSP_OPCODE) begin
          next_opcode = byte_in;
          unique case (byte_in)
            gsp_pkg::OP_WREN, gsp_pkg::OP_WRDI: next_mode = GSP_SIMPLE;
            gsp_pkg::OP_WRSR1: next_mode = GSP_WRSR; // [RULE13]
            gsp_pkg::OP_RDSR: begin
              next_mode = GSP_RDSR;
              next_out_sh = stat_byte;
            end
            default: next_mode = GSP_IGNORE;
          endcase
        end else if (mode == GSP_WRSR && !have_data) begin
          next_wr_data = byte_in;
          next_have_data = 1'b1;
        end
      end
    end else if (!cs_n_s && sck_fall && mode == GSP_RDSR) begin
      next_so_q = (bit_cnt == 3'h0) ? stat_byte[7] : out_sh[7];
      next_out_sh = (bit_cnt == 3'h0) ? {stat_byte[6:0], stat_byte[7]} : {out_sh[6:0], out_sh[7]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
      mode <= GSP_IDLE;
      bit_cnt <= 3'h0;
      sh_in <= 8'h00;
      opcode <= 8'h00;
      wr_data <= 8'h00;
      have_data <= 1'b0;
      out_sh <= 8'h00;
      so_q <= 1'b0;
      write_latch_bit <= gsp_pkg::RST_WEL;
      lock <= gsp_pkg::RST_LOCK;
      prot <= {NUM_SECTORS{gsp_pkg::RST_SECTOR}}; // [RULE16]
      ev <= gsp_pkg::RST_EVENT;
    end else begin
      sck_d <= sck_s;
      cs_n_d <= cs_n_s;
      mode <= next_mode;
      bit_cnt <= next_bit_cnt;
      sh_in <= next_sh_in;
      opcode <= next_opcode;
      wr_data <= next_wr_data;
      have_data <= next_have_data;
      out_sh <= next_out_sh;
      so_q <= next_so_q;
      write_latch_bit <= next_wel;
      lock <= next_lock;
      prot <= next_prot;
      ev <= next_ev;
    end
  end

  assign spi_so = so_q;
  assign spi_so_oe = ~cs_n_s && (mode == GSP_RDSR);

  // Register bus slave
  logic aw_full, next_aw_full;
  logic [7:0] aw_addr, next_aw_addr;
  logic w_full, next_w_full;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [gsp_pkg::EV_W-1:0] evt, next_evt;
  logic [gsp_pkg::EV_W-1:0] en, next_en;
  logic [NUM_SECTORS-1:0] next_susp;
  logic [gsp_pkg::EV_W-1:0] clr;
  logic do_write;

  assign s_axi_awready = ~aw_full && ~bvalid;
  assign s_axi_wready = ~w_full && ~bvalid;
  assign s_axi_arready = ~rvalid;
  assign do_write = aw_full && w_full && ~bvalid;

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_en = en;
    next_susp = susp;
    clr = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = gsp_pkg::RESP_OKAY;
      unique case ({aw_addr[7:2], 2'b00})
        gsp_pkg::REG_CLEAR: clr = w_strb[0] ? w_data[gsp_pkg::EV_W-1:0] : '0;
        gsp_pkg::REG_ENABLE: begin
          if (w_strb[0]) begin
            next_en = w_data[gsp_pkg::EV_W-1:0];
          end
        end
        gsp_pkg::REG_SUSP: begin
          for (int i = 0; i < NUM_SECTORS; i++) begin
            if (w_strb[i/8]) begin
              next_susp[i] = w_data[i];
            end
          end
        end
        gsp_pkg::REG_EVENT, gsp_pkg::REG_PROT, gsp_pkg::REG_STATBYTE: begin
        end
        default: next_bresp = gsp_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = gsp_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        gsp_pkg::REG_EVENT: next_rdata[gsp_pkg::EV_W-1:0] = evt;
        gsp_pkg::REG_ENABLE: next_rdata[gsp_pkg::EV_W-1:0] = en;
        gsp_pkg::REG_CLEAR: begin
        end
        gsp_pkg::REG_PROT: next_rdata[NUM_SECTORS-1:0] = prot;
        gsp_pkg::REG_SUSP: next_rdata[NUM_SECTORS-1:0] = susp;
        gsp_pkg::REG_STATBYTE: next_rdata[7:0] = stat_byte;
        default: next_rresp = gsp_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // Set wins over clear
    next_evt = (evt & ~clr) | ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= gsp_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= gsp_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
      evt <= gsp_pkg::RST_EVENT;
      en <= gsp_pkg::RST_ENABLE;
      susp <= '0;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      evt <= next_evt;
      en <= next_en;
      susp <= next_susp;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign irq = |(evt & en);

endmodule : gsp_decoder

/* sim/gsp_host_model.sv */
// Serial host model that frames opcodes and data bytes, mode 0
module gsp_host_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_si,
  input wire logic spi_so
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx;
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
    rx = 8'h00;
  end
  // Sends v[15:8], then v[7:0] when two is set; rx keeps last 8 bits seen
  task automatic frame(input logic [15:0] v, input logic two);
    int n;
    n = two ? 16 : 8;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      spi_si <= v[15-i];
      repeat (4) @(posedge clk);
      spi_sck <= 1'b1;
      repeat (4) @(posedge clk);
      spi_sck <= 1'b0;
      rx <= {rx[6:0], spi_so};
    end
    repeat (4) @(posedge clk);
    spi_cs_n <= 1'b1;
    spi_si <= ~spi_si;
    repeat (12) @(posedge clk);
  endtask : frame
endmodule : gsp_host_model

/* sim/gsp_decoder_chk.sv */
// Bus and link timing checker for the protect decoder
module gsp_decoder_chk #(
  parameter int NUM_SECTORS = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_so,
  input wire logic spi_so_oe,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_take |=> ##1 s_axi_bvalid)
    else $error("no write response after address and data");
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("no read data after read address");
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_out_idle: assert property (spi_cs_n [*6] |-> !spi_so_oe)
    else $error("data out driven while deselected");
  chk_out_steady: assert property (spi_so_oe && $changed(spi_so) |-> !spi_sck)
    else $error("data out changed while clock high");
endmodule : gsp_decoder_chk
bind gsp_decoder gsp_decoder_chk #(.NUM_SECTORS(NUM_SECTORS)) i_chk (
  .clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
  .spi_so(spi_so), .spi_so_oe(spi_so_oe), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

/* sim/test_gsp_decoder.sv */
// Self-checking bench for the global sector protect decoder
module test_gsp_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_wvalid = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdv;
  logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, irq;
  logic [31:0] prot_m = 32'hffffffff;
  logic lock_m = 1'b0;
  logic susp_m = 1'b0;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  gsp_decoder i_dut (
    .clk(clk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe), .wp_n(wp_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
  );
  gsp_host_model i_host (
    .clk(clk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .spi_so(spi_so_oe ? spi_so : ~spi_so)
  );
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic st();
    logic [1:0] sw;
    sw = (prot_m == '1) ? 2'h3 : (prot_m == '0) ? 2'h0 : 2'h1;
    rd(gsp_pkg::REG_PROT, rdv);
    cmp(rdv, prot_m);
    rd(gsp_pkg::REG_STATBYTE, rdv);
    cmp(rdv, {24'h0, lock_m, 2'h0, wp_n, sw, 2'h0});
  endtask : st
  task automatic wsr(input logic [7:0] d);
    i_host.frame({gsp_pkg::OP_WREN, 8'h00}, 1'b0);
    i_host.frame({gsp_pkg::OP_WRSR1, d}, 1'b1);
    if (wp_n || !lock_m) begin
      if (!lock_m && !(d[5:2] == 4'hf && susp_m)) begin
        if (d[5:2] == 4'hf) prot_m = '1;
        if (d[5:2] == 4'h0) prot_m = '0;
      end
      lock_m = d[7];
    end
    st();
  endtask : wsr
  task automatic t_reset();
    st();
    rd(8'h40, rdv);
    cmp({30'h0, resp}, {30'h0, gsp_pkg::RESP_SLVERR});
    wr(8'h40, 32'h0);
    cmp({30'h0, resp}, {30'h0, gsp_pkg::RESP_SLVERR});
  endtask : t_reset
  task automatic t_nowel();
    i_host.frame({gsp_pkg::OP_WRSR1, 8'h00}, 1'b1);
    st();
    rd(gsp_pkg::REG_EVENT, rdv);
    cmp(rdv & 32'h8, 32'h8);
    wr(gsp_pkg::REG_CLEAR, 32'hf);
    cmp({30'h0, resp}, {30'h0, gsp_pkg::RESP_OKAY});
    i_host.frame({gsp_pkg::OP_WREN, 8'h00}, 1'b0);
    rd(gsp_pkg::REG_STATBYTE, rdv);
    cmp(rdv & 32'h2, 32'h2);
    i_host.frame({gsp_pkg::OP_WRDI, 8'h00}, 1'b0);
    i_host.frame({gsp_pkg::OP_WRSR1, 8'h00}, 1'b1);
    st();
    rd(gsp_pkg::REG_EVENT, rdv);
    cmp(rdv, 32'h8);
  endtask : t_nowel
  task automatic t_table();
    logic [7:0] v [10] = '{8'h00, 8'h04, 8'h38, 8'h7f, 8'h00, 8'hff, 8'h00, 8'h00,
      8'hf0, 8'h0f};
    for (int i = 0; i < 10; i++) wsr(v[i]);
  endtask : t_table
  task automatic t_hwlock();
    wsr(8'hf0);
    wr(gsp_pkg::REG_CLEAR, 32'hf);
    @(posedge clk);
    wp_n <= 1'b0;
    wsr(8'h0f);
    rd(gsp_pkg::REG_EVENT, rdv);
    cmp(rdv, 32'h8);
    @(posedge clk);
    wp_n <= 1'b1;
    wsr(8'h0f);
  endtask : t_hwlock
  task automatic t_suspend();
    wr(gsp_pkg::REG_SUSP, 32'h1);
    susp_m = 1'b1;
    wsr(8'h7f);
    rd(gsp_pkg::REG_EVENT, rdv);
    cmp(rdv & 32'h4, 32'h4);
    wr(gsp_pkg::REG_SUSP, 32'h0);
    susp_m = 1'b0;
  endtask : t_suspend
  task automatic t_irq();
    wr(gsp_pkg::REG_CLEAR, 32'hf);
    wr(gsp_pkg::REG_ENABLE, 32'h1);
    wsr(8'h00);
    cmp({31'h0, irq}, 32'h0);
    wsr(8'h7f);
    cmp({31'h0, irq}, 32'h1);
    wr(gsp_pkg::REG_CLEAR, 32'h1);
    cmp({31'h0, irq}, 32'h0);
  endtask : t_irq
  task automatic t_readback();
    i_host.frame({gsp_pkg::OP_RDSR, 8'h00}, 1'b1);
    cmp({24'h0, i_host.rx}, 32'h1c);
  endtask : t_readback
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_nowel();
    t_table();
    t_hwlock();
    t_suspend();
    t_irq();
    t_readback();
    wrap_up();
  end
endmodule : test_gsp_decoder
